// file: mfps_pkg.sv
// Shared constants for the multifunction pin select block.
// Assumes a single 10 MHz core clock and synchronous active-low reset.
package mfps_pkg;
   // Pin count of the low general-purpose port
   localparam int PIN_COUNT = 5;
   // Pin positions within the port
   localparam int PIN_IRQ_SS = 0;
   localparam int PIN_SCLK = 1;
   localparam int PIN_MISO = 2;
   localparam int PIN_MOSI = 3;
   localparam int PIN_CLK = 4;
   // Core and output clock rates, in Hz
   localparam int CORE_CLK_HZ = 10_000_000;
   localparam int CLK_OUT_HZ = 2_560_000;
   // Phase accumulator: one toggle per overflow, two toggles per output period
   localparam int ACC_W = 24;
   localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CORE_CLK_HZ);
   localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(2 * CLK_OUT_HZ);
   localparam logic [ACC_W-1:0] ACC_RESET = 24'h000000;
   // Pin function selections
   typedef enum logic [1:0] {
      MFPS_SEL_GPIO = 2'b00,
      MFPS_SEL_IRQ = 2'b01,
      MFPS_SEL_ALT = 2'b10
   } mfps_sel_type;
   // Values after reset
   localparam logic [4:0] PIN_OE_RESET = 5'h00;
   localparam logic [4:0] PIN_OUT_RESET = 5'h00;
   localparam logic [4:0] SYNC_RESET = 5'h1F; // Pins idle high on weak pull-ups
endpackage

// file: mfps_clk_div.sv
// Fractional divider giving one-cycle toggle enables for the clock output pin.
// Assumes the core clock rate in the package; average toggle rate is exact.
`timescale 1ns/10ps
module mfps_clk_div (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   output logic toggle_en_out
);
   logic [mfps_pkg::ACC_W-1:0] acc_q, acc_d;
   logic toggle_d;

   // Accumulate step; wrap at the core rate and flag a toggle
   always_comb begin
      if (acc_q + mfps_pkg::ACC_STEP >= mfps_pkg::ACC_MOD) begin
         acc_d = mfps_pkg::ACC_W'(acc_q + mfps_pkg::ACC_STEP - mfps_pkg::ACC_MOD);
         toggle_d = 1'b1;
      end else begin
         acc_d = mfps_pkg::ACC_W'(acc_q + mfps_pkg::ACC_STEP);
         toggle_d = 1'b0;
      end
   end

   // Registers only
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         acc_q <= mfps_pkg::ACC_RESET;
         toggle_en_out <= 1'b0;
      end else begin
         acc_q <= acc_d;
         toggle_en_out <= toggle_d;
      end
   end
endmodule // mfps_clk_div

// file: mfps_pin_select.sv
// Pin function multiplexer for port pins 0..4, debug data output and boot strap.
// Assumes pins come from outside (synchronised here) and control from core logic.
`timescale 1ns/10ps
module mfps_pin_select (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   // Select fields, loaded on cfg_load_in
   input wire logic cfg_load_in,
   input wire logic [1:0] pin0_sel_in,
   input wire logic pin1_alt_in,
   input wire logic pin2_alt_in,
   input wire logic pin3_alt_in,
   input wire logic pin4_alt_in,
   // General I/O controller side
   input wire logic [4:0] gpio_data_in,
   input wire logic [4:0] gpio_oe_in,
   output logic [4:0] gpio_pin_out,
   // SPI controller side
   input wire logic spi_master_in,
   input wire logic spi_miso_data_in,
   input wire logic spi_mosi_data_in,
   output logic spi_slave_select_n_out,
   output logic spi_sclk_out,
   output logic spi_miso_out,
   output logic spi_mosi_out,
   // Interrupt controller side
   output logic ext_interrupt_request_zero_out,
   // Port pins
   input wire logic [4:0] pin_in,
   output logic [4:0] pin_out,
   output logic [4:0] pin_oe_out,
   // Debug port
   input wire logic dbg_tdo_data_in,
   input wire logic dbg_tdo_en_in,
   input wire logic debug_reset_input_in,
   output logic dbg_tdo_out,
   output logic dbg_tdo_oe_out,
   // Boot logic
   output logic boot_serial_out,
   output logic boot_valid_out
);
   // Synchroniser stages, select fields and next values of every register
   logic [4:0] sync1_q, sync2_q;
   logic dbg_rst_sync1_q, dbg_rst_sync2_q;
   logic [1:0] sel0_q, sel0_d;
   logic [4:1] alt_q, alt_d;
   logic [4:0] pin_out_d, pin_oe_d, gpio_pin_d;
   logic clk_q, clk_d;
   logic irq_d, ss_n_d, sclk_d, miso_d, mosi_d;
   logic tdo_d, tdo_oe_d;
   logic boot_serial_d, boot_valid_d;
   logic toggle_en;

   // True when the given alternate field is active for this pin
   function automatic logic mfps_is_alt(input logic [4:1] alt, input int idx);
      return alt[idx];
   endfunction

   // Level an alternate input function sees: the pin when routed, else its idle level
   function automatic logic mfps_alt_level(input logic [4:1] alt, input int idx,
         input logic [4:0] lvl, input logic idle);
      return alt[idx] ? lvl[idx] : idle;
   endfunction

   // Toggle enables for the clock output pin
   mfps_clk_div u_clk_div (
      .core_clk_in(core_clk_in),
      .resetn_in(resetn_in),
      .toggle_en_out(toggle_en)
   );

   // Two-stage pin synchronisers; only the second stage is read. Reset loads
   // the pull-up level so nothing downstream sees a false low on release.
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         sync1_q <= mfps_pkg::SYNC_RESET;
         sync2_q <= mfps_pkg::SYNC_RESET;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
      end
   end

   // Debug reset strap synchroniser keeps running through reset on purpose:
   // the boot capture at the first edge after release must see the settled
   // strap level, not a reset value. Reset must therefore last two edges at
   // least; a strap that changes later is not seen until the next reset.
   always_ff @(posedge core_clk_in) begin
      dbg_rst_sync1_q <= debug_reset_input_in;
      dbg_rst_sync2_q <= dbg_rst_sync1_q;
   end

   // Select fields hold until the next load
   // A load takes all five fields at once, so no pin sees half a change
   always_comb begin
      sel0_d = sel0_q;
      alt_d = alt_q;
      if (cfg_load_in) begin
         // Unused code 2'b11 falls back to general I/O
         sel0_d = (pin0_sel_in == 2'b11) ? 2'(mfps_pkg::MFPS_SEL_GPIO) : pin0_sel_in;
         alt_d = {pin4_alt_in, pin3_alt_in, pin2_alt_in, pin1_alt_in};
      end
   end

   // Clock output toggles on each divider enable, even when not routed
   // Running free keeps the phase independent of the select, for a little power
   always_comb begin
      clk_d = toggle_en ? ~clk_q : clk_q;
   end

   // Pin drive: only the selected function reaches output and enable
   // Starting from general I/O and overriding per pin means a pin that no
   // alternate claims stays under general I/O control, never under two owners
   always_comb begin
      pin_out_d = gpio_data_in;
      pin_oe_d = gpio_oe_in;
      // Pin 0: interrupt and slave select are inputs only
      if (sel0_q != 2'(mfps_pkg::MFPS_SEL_GPIO)) begin
         pin_out_d[mfps_pkg::PIN_IRQ_SS] = 1'b0;
         pin_oe_d[mfps_pkg::PIN_IRQ_SS] = 1'b0;
      end
      // Pin 1: serial clock is a slave input here
      if (mfps_is_alt(alt_q, mfps_pkg::PIN_SCLK)) begin
         pin_out_d[mfps_pkg::PIN_SCLK] = 1'b0;
         pin_oe_d[mfps_pkg::PIN_SCLK] = 1'b0;
      end
      // Pin 2: driven by the slave, received by the master
      if (mfps_is_alt(alt_q, mfps_pkg::PIN_MISO)) begin
         pin_out_d[mfps_pkg::PIN_MISO] = spi_miso_data_in;
         pin_oe_d[mfps_pkg::PIN_MISO] = ~spi_master_in;
      end
      // Pin 3: driven by the master, received by the slave
      if (mfps_is_alt(alt_q, mfps_pkg::PIN_MOSI)) begin
         pin_out_d[mfps_pkg::PIN_MOSI] = spi_mosi_data_in;
         pin_oe_d[mfps_pkg::PIN_MOSI] = spi_master_in;
      end
      // Pin 4: continuous clock output
      if (mfps_is_alt(alt_q, mfps_pkg::PIN_CLK)) begin
         pin_out_d[mfps_pkg::PIN_CLK] = clk_d;
         pin_oe_d[mfps_pkg::PIN_CLK] = 1'b1;
      end
   end

   // Inbound routing; deselected alternate functions see their idle level, general I/O always reads the pin, so the
   // peripheral behind a pin stays quiet while the pin does general I/O
   always_comb begin
      gpio_pin_d = sync2_q;
      irq_d = (sel0_q == 2'(mfps_pkg::MFPS_SEL_IRQ)) && sync2_q[mfps_pkg::PIN_IRQ_SS];
      // Slave select idles inactive high so a stray low cannot start a transfer
      ss_n_d = (sel0_q == 2'(mfps_pkg::MFPS_SEL_ALT)) ? sync2_q[mfps_pkg::PIN_IRQ_SS] : 1'b1;
      sclk_d = mfps_alt_level(alt_q, mfps_pkg::PIN_SCLK, sync2_q, 1'b0);
      miso_d = mfps_alt_level(alt_q, mfps_pkg::PIN_MISO, sync2_q, 1'b0);
      mosi_d = mfps_alt_level(alt_q, mfps_pkg::PIN_MOSI, sync2_q, 1'b0);
   end

   // Debug data output follows the debug logic's enable only
   // Pin selects cannot reach it, so port setup never disturbs a debug session
   always_comb begin
      tdo_d = dbg_tdo_data_in;
      tdo_oe_d = dbg_tdo_en_in;
   end

   // Boot strap caught once, at the first edge after reset release, from the
   // free-running strap synchroniser; the flag then holds so a strap that
   // moves later cannot switch the boot path under running code
   always_comb begin
      boot_serial_d = boot_serial_out;
      boot_valid_d = boot_valid_out;
      if (!boot_valid_out) begin
         boot_serial_d = dbg_rst_sync2_q;
         boot_valid_d = 1'b1;
      end
   end

   // Registers only; reset leaves every pin an input and every alternate off
   // Every output comes from here, so pins and flags change only on the clock edge
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         sel0_q <= 2'(mfps_pkg::MFPS_SEL_GPIO);
         alt_q <= 4'h0;
         clk_q <= 1'b0;
         pin_out <= mfps_pkg::PIN_OUT_RESET;
         pin_oe_out <= mfps_pkg::PIN_OE_RESET;
         gpio_pin_out <= mfps_pkg::SYNC_RESET;
         ext_interrupt_request_zero_out <= 1'b0;
         spi_slave_select_n_out <= 1'b1;
         spi_sclk_out <= 1'b0;
         spi_miso_out <= 1'b0;
         spi_mosi_out <= 1'b0;
         dbg_tdo_out <= 1'b0;
         dbg_tdo_oe_out <= 1'b0;
         boot_serial_out <= 1'b0;
         boot_valid_out <= 1'b0;
      end else begin
         sel0_q <= sel0_d;
         alt_q <= alt_d;
         clk_q <= clk_d;
         pin_out <= pin_out_d;
         pin_oe_out <= pin_oe_d;
         gpio_pin_out <= gpio_pin_d;
         ext_interrupt_request_zero_out <= irq_d;
         spi_slave_select_n_out <= ss_n_d;
         spi_sclk_out <= sclk_d;
         spi_miso_out <= miso_d;
         spi_mosi_out <= mosi_d;
         dbg_tdo_out <= tdo_d;
         dbg_tdo_oe_out <= tdo_oe_d;
         boot_serial_out <= boot_serial_d;
         boot_valid_out <= boot_valid_d;
      end
   end
endmodule // mfps_pin_select

// file: mfps_pin_select_chk.sv
// Checker for the pin select block, bound to it below.
// Assumes synchronous active-low reset held for at least four cycles.
`timescale 1ns/10ps
module mfps_chk (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic cfg_load_in,
   input wire logic pin4_alt_in,
   input wire logic [4:0] pin_in,
   input wire logic [4:0] pin_out,
   input wire logic [4:0] pin_oe_out,
   input wire logic spi_slave_select_n_out,
   input wire logic spi_sclk_out,
   input wire logic ext_interrupt_request_zero_out,
   input wire logic dbg_tdo_en_in,
   input wire logic dbg_tdo_oe_out,
   input wire logic boot_valid_out
);
   logic alt4_q;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   // Own copy of the clock-out select; pin 4 must toggle while it is set
   always_ff @(posedge core_clk_in) alt4_q <= resetn_in && (cfg_load_in ? pin4_alt_in : alt4_q);
   chk_reset_idle: assert property ($rose(resetn_in) |-> pin_oe_out == 5'h00 && !dbg_tdo_oe_out)
      else $error("pin driven after reset");
   chk_boot_flag: assert property ($rose(resetn_in) |-> ##[1:2] boot_valid_out)
      else $error("boot flag late");
   chk_boot_hold: assert property (boot_valid_out |=> boot_valid_out)
      else $error("boot flag dropped");
   chk_tdo_follow: assert property ($past(resetn_in) |-> dbg_tdo_oe_out == $past(dbg_tdo_en_in))
      else $error("debug enable wrong");
   // Inbound checks skip four cycles so synchroniser reset values pass
   chk_irq_level: assert property (ext_interrupt_request_zero_out && $past(resetn_in, 4)
      |-> $past(pin_in[0], 3)) else $error("request without high pin");
   chk_select_level: assert property (!spi_slave_select_n_out && $past(resetn_in, 4)
      |-> !$past(pin_in[0], 3)) else $error("select without low pin");
   chk_sclk_level: assert property (spi_sclk_out && $past(resetn_in, 4)
      |-> $past(pin_in[1], 3)) else $error("serial clock without pin");
   chk_clk_toggle: assert property (alt4_q [*4] |-> pin_oe_out[4] &&
      (pin_out[4] != $past(pin_out[4]) || $past(pin_out[4]) != $past(pin_out[4], 2)))
      else $error("clock output stuck");
endmodule // mfps_chk
bind mfps_pin_select mfps_chk u_chk (.core_clk_in, .resetn_in, .cfg_load_in, .pin4_alt_in,
   .pin_in, .pin_out, .pin_oe_out, .spi_slave_select_n_out, .spi_sclk_out,
   .ext_interrupt_request_zero_out, .dbg_tdo_en_in, .dbg_tdo_oe_out, .boot_valid_out);

// file: mfps_pad_peer.sv
// Far side of the pins: pull-ups, outside drivers, debug reset strap.
// Where the bench drives a pin that the block also drives, the block drive wins.
`timescale 1ns/10ps
module mfps_pad_peer (
   input wire logic [4:0] drive_in,
   input wire logic [4:0] drive_en_in,
   input wire logic [4:0] ext_en_in,
   input wire logic [4:0] ext_level_in,
   input wire logic strap_in,
   output logic [4:0] pad_level_out,
   output logic dbg_reset_out
);
   // Block drive first, then outside source high or low, else weak pull-up
   assign pad_level_out = (drive_in & drive_en_in) | ~drive_en_in & (~ext_en_in | ext_level_in);
   // Pull-down: an open strap means normal start-up
   assign dbg_reset_out = strap_in;
endmodule // mfps_pad_peer

// file: mfps_pin_select_tb.sv
// Self-checking bench for the pin select block.
// Assumes the pad peer and the bound checker; 10 MHz clock.
`timescale 1ns/10ps
module mfps_pin_select_tb;
   logic core_clk_in = 1'b0, resetn_in = 1'b0, cfg_load_in = 1'b0, spi_master_in = 1'b0;
   logic pin1_alt_in = 1'b0, pin2_alt_in = 1'b0, pin3_alt_in = 1'b0, pin4_alt_in = 1'b0;
   logic spi_miso_data_in = 1'b0, spi_mosi_data_in = 1'b0, dbg_tdo_data_in = 1'b0;
   logic dbg_tdo_en_in = 1'b0, strap = 1'b0, debug_reset_input_in;
   logic [1:0] pin0_sel_in = 2'h0;
   logic [4:0] gpio_data_in = 5'h00, gpio_oe_in = 5'h00, ext_en = 5'h00, ext_lvl = 5'h00;
   logic [4:0] gpio_pin_out, pin_in, pin_out, pin_oe_out;
   logic spi_slave_select_n_out, spi_sclk_out, spi_miso_out, spi_mosi_out, dbg_tdo_out;
   logic ext_interrupt_request_zero_out, dbg_tdo_oe_out, boot_serial_out, boot_valid_out;
   int n_errors = 0, checks_done = 0, cycles = 0;
   mfps_pin_select dut (.core_clk_in, .resetn_in, .cfg_load_in, .pin0_sel_in, .pin1_alt_in,
      .pin2_alt_in, .pin3_alt_in, .pin4_alt_in, .gpio_data_in, .gpio_oe_in, .gpio_pin_out,
      .spi_master_in, .spi_miso_data_in, .spi_mosi_data_in, .spi_slave_select_n_out,
      .spi_sclk_out, .spi_miso_out, .spi_mosi_out, .ext_interrupt_request_zero_out, .pin_in,
      .pin_out, .pin_oe_out, .dbg_tdo_data_in, .dbg_tdo_en_in, .debug_reset_input_in,
      .dbg_tdo_out, .dbg_tdo_oe_out, .boot_serial_out, .boot_valid_out);
   mfps_pad_peer peer (.drive_in(pin_out), .drive_en_in(pin_oe_out), .ext_en_in(ext_en),
      .ext_level_in(ext_lvl), .strap_in(strap), .pad_level_out(pin_in),
      .dbg_reset_out(debug_reset_input_in));
   always #50 core_clk_in = ~core_clk_in;
   // Ceiling about ten times the few hundred cycles the run needs
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Wait out select, drive and the three-stage inbound path
   task automatic settle();
      repeat (5) @(posedge core_clk_in);
      @(negedge core_clk_in);
   endtask
   task automatic load(input logic [1:0] s0, input logic [4:1] a);
      @(posedge core_clk_in);
      cfg_load_in <= 1'b1;
      pin0_sel_in <= s0;
      {pin4_alt_in, pin3_alt_in, pin2_alt_in, pin1_alt_in} <= a;
      @(posedge core_clk_in);
      cfg_load_in <= 1'b0;
      settle();
   endtask
   task automatic do_reset();
      @(posedge core_clk_in);
      resetn_in <= 1'b0;
      repeat (20) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      settle();
   endtask
   task automatic t_reset();
      do_reset();
      chk("pin_oe", 8'h00, pin_oe_out);
      chk("pin_read", 8'h1F, gpio_pin_out);
      chk("tdo_oe", 8'h00, dbg_tdo_oe_out);
      chk("boot", 8'h02, {boot_valid_out, boot_serial_out});
   endtask
   // Code 11 must behave as general I/O
   task automatic t_gpio();
      load(2'h3, 4'h0);
      @(posedge core_clk_in);
      gpio_oe_in <= 5'h1F;
      gpio_data_in <= 5'h0A;
      settle();
      chk("pin_oe", 8'h1F, pin_oe_out);
      chk("pin_read", 8'h0A, gpio_pin_out);
   endtask
   task automatic t_pin0();
      for (int s = 0; s < 3; s++) begin
         load(s[1:0], 4'h0);
         for (int l = 0; l < 2; l++) begin
            @(posedge core_clk_in);
            ext_en <= 5'h01;
            ext_lvl <= {4'h0, l[0]};
            settle();
            chk("oe0", s == 0, pin_oe_out[0]);
            chk("irq", s == 1 && l == 1, ext_interrupt_request_zero_out);
            chk("ss_n", s != 2 || l == 1, spi_slave_select_n_out);
         end
      end
   endtask
   // Block drives its data pin high, the outside drives the other low,
   // so neither a pull-up nor a stuck route can pass
   task automatic t_spi();
      load(2'h0, 4'h7);
      for (int m = 0; m < 2; m++) begin
         @(posedge core_clk_in);
         spi_master_in <= m[0];
         spi_miso_data_in <= ~m[0];
         spi_mosi_data_in <= m[0];
         ext_en <= m[0] ? 5'h06 : 5'h0A;
         ext_lvl <= 5'h02;
         settle();
         chk("spi_oe", m[0] ? 8'h19 : 8'h15, pin_oe_out);
         chk("spi_in", m[0] ? 8'h05 : 8'h06, {spi_sclk_out, spi_miso_out, spi_mosi_out});
         chk("pin_read", m[0] ? 8'h0A : 8'h06, gpio_pin_out);
      end
   endtask
   task automatic t_clk();
      int n = 0;
      logic prev;
      load(2'h0, 4'h8);
      prev = pin_out[4];
      repeat (250) begin
         @(negedge core_clk_in);
         n += (pin_out[4] !== prev);
         prev = pin_out[4];
      end
      chk("clk_toggles", 8'h80, n[7:0]);
   endtask
   task automatic t_dbg();
      @(posedge core_clk_in);
      dbg_tdo_en_in <= 1'b1;
      dbg_tdo_data_in <= 1'b1;
      strap <= 1'b1;
      settle();
      chk("tdo", 8'h03, {dbg_tdo_oe_out, dbg_tdo_out});
      do_reset();
      chk("boot", 8'h03, {boot_valid_out, boot_serial_out});
   endtask
   task automatic print_verdict();
      if (n_errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      t_reset();
      t_gpio();
      t_pin0();
      t_spi();
      t_clk();
      t_dbg();
      print_verdict();
   end
endmodule // mfps_pin_select_tb
